//--- design/lbs_pkg.sv
// Constants and types shared by the LED blink and dimming sequencer
package lbs_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_FIRST_CTRL = 8'h47;
	localparam logic [7:0] OFF_PHASE1 = 8'h48;
	localparam logic [7:0] OFF_PHASE2 = 8'h49;
	localparam logic [7:0] OFF_PHASE3 = 8'h4A;
	localparam logic [7:0] OFF_PHASE4 = 8'h4B;
	localparam logic [7:0] OFF_PAUSE = 8'h4C;
	localparam logic [7:0] OFF_DUTY = 8'h4D;
	localparam logic [7:0] OFF_ON_TIME = 8'h4E;
	localparam logic [7:0] OFF_SECOND_CTRL = 8'h4F;
	localparam int REG_COUNT = 9;

	// ------------------------------------------------------------
	// Field masks and reset value
	// ------------------------------------------------------------
	localparam logic [7:0] MASK_LEN = 8'h7F;
	localparam logic [7:0] MASK_CODE5 = 8'h1F;
	localparam logic [7:0] MASK_CTRL = 8'h2F;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int RAMP_BIT = 5;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int DIM_PERIOD_NS = 8000000;
	localparam int STEP_NS = 64000000;
	localparam int DIM_SLOTS = 32;
	localparam int SLOT_CYCLES = DIM_PERIOD_NS / (DIM_SLOTS * CLK_PERIOD_NS);
	localparam int PERIODS_PER_STEP = STEP_NS / DIM_PERIOD_NS;
	localparam logic [4:0] LAST_SLOT = 5'h1F;
	localparam logic [2:0] LAST_PERIOD = 3'(PERIODS_PER_STEP - 1);

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		PH_FIRST = 3'b000,
		PH_SECOND = 3'b001,
		PH_THIRD = 3'b010,
		PH_FOURTH = 3'b011,
		PH_PAUSE = 3'b100
	} lbs_phase_t;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lbs_req_t;

endpackage

//--- design/lbs_slot_tick.sv
// Divider giving one enable pulse per dimming slot
`timescale 1ns/1ns
module lbs_slot_tick #(
	parameter int CYCLES = 25000
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RST_N_I,
	// Slot enable
	output logic tick_o
);
	logic [15:0] cnt;

	// Free-running count; pulse on the last cycle of every slot
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			cnt <= 16'h0000;
			tick_o <= 1'b0;
		end else if (cnt == 16'(CYCLES - 1)) begin
			cnt <= 16'h0000;
			tick_o <= 1'b1;
		end else begin
			cnt <= cnt + 16'h0001;
			tick_o <= 1'b0;
		end
	end

endmodule

//--- design/lbs_sequencer.sv
// LED blink and dimming sequencer with its control registers
//
// What this block does
// - First phase lasts its 7-bit code times 64 ms, 0 to 127 steps.
// - Second phase lasts its 7-bit code times 64 ms.
// - Third phase lasts its 7-bit code times 64 ms.
// - Fourth phase lasts its 7-bit code times 64 ms.
// - Pause phase lasts its 7-bit code times 64 ms.
// - Dimming wave has 8 ms period, high (duty+1)/32 of it.
// - Duty zero gives 250 us high, 7.75 ms low.
// - Duty all ones keeps the dimming wave high whenever the LED is lit.
// - Reserved bits ignore writes and read zero.
// - All registers clear to zero on reset.
// - Second driver current code sits in bits 3 to 0, resets zero.
// - First driver current code sits in bits 3 to 0 of its control register.
`timescale 1ns/1ns
module lbs_sequencer #(
	parameter int SLOT_CYCLES = lbs_pkg::SLOT_CYCLES
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RST_N_I,
	// Register access from the serial control logic
	input wire lbs_pkg::lbs_req_t REG_REQ_I,
	output logic [7:0] REG_RDATA_O,
	// Driver controls
	output logic DIM_WAVE_O,
	output logic [3:0] FIRST_SINK_LEVEL_O,
	output logic [3:0] SECOND_SINK_LEVEL_O,
	output logic SECOND_RAMP_EN_O,
	output logic [2:0] PHASE_O
);

	// ------------------------------------------------------------
	// Register helpers
	// ------------------------------------------------------------
	// Writable bits of each offset; everything else is reserved
	function automatic logic [7:0] wmask(input logic [7:0] addr);
		unique case (addr)
			lbs_pkg::OFF_FIRST_CTRL, lbs_pkg::OFF_SECOND_CTRL: wmask = lbs_pkg::MASK_CTRL;
			lbs_pkg::OFF_DUTY, lbs_pkg::OFF_ON_TIME: wmask = lbs_pkg::MASK_CODE5;
			lbs_pkg::OFF_PHASE1, lbs_pkg::OFF_PHASE2, lbs_pkg::OFF_PHASE3,
			lbs_pkg::OFF_PHASE4, lbs_pkg::OFF_PAUSE: wmask = lbs_pkg::MASK_LEN;
			default: wmask = 8'h00;
		endcase
	endfunction

	function automatic logic [3:0] index(input logic [7:0] addr);
		index = 4'(addr - lbs_pkg::OFF_FIRST_CTRL);
	endfunction

	logic [7:0] regs [lbs_pkg::REG_COUNT];

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	// Masked writes keep reserved bits at zero at all times
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			for (int i = 0; i < lbs_pkg::REG_COUNT; i++) begin
				regs[i] <= lbs_pkg::REG_RESET;
			end
		end else if (REG_REQ_I.wr && wmask(REG_REQ_I.addr) != 8'h00) begin
			regs[index(REG_REQ_I.addr)] <= REG_REQ_I.wdata & wmask(REG_REQ_I.addr);
		end
	end

	// Read data registered one cycle after the address; unmapped reads zero
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			REG_RDATA_O <= 8'h00;
		end else if (wmask(REG_REQ_I.addr) != 8'h00) begin
			REG_RDATA_O <= regs[index(REG_REQ_I.addr)];
		end else begin
			REG_RDATA_O <= 8'h00;
		end
	end

	logic [6:0] len [5];
	logic [4:0] duty_code;
	logic [4:0] on_code;
	assign len[0] = regs[1][6:0];
	assign len[1] = regs[2][6:0];
	assign len[2] = regs[3][6:0];
	assign len[3] = regs[4][6:0];
	assign len[4] = regs[5][6:0];
	assign duty_code = regs[6][4:0];
	assign on_code = regs[7][4:0];

	// ------------------------------------------------------------
	// Time base: 32 slots make 8 ms, 8 periods make 64 ms
	// ------------------------------------------------------------
	logic slot_tick;
	logic [4:0] slot;
	logic [2:0] period;
	logic step_tick;

	lbs_slot_tick #(.CYCLES(SLOT_CYCLES)) lbs_slot_tick_i (
		.CLK_I(CLK_I),
		.RST_N_I(RST_N_I),
		.tick_o(slot_tick)
	);

	assign step_tick = slot_tick && slot == lbs_pkg::LAST_SLOT && period == lbs_pkg::LAST_PERIOD;

	// Slot and period counters, counted rather than taken from a clock
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			slot <= 5'h00;
			period <= 3'h0;
		end else if (slot_tick) begin
			slot <= slot + 5'h01;
			if (slot == lbs_pkg::LAST_SLOT) begin
				period <= period + 3'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Phase sequencer
	// ------------------------------------------------------------
	lbs_pkg::lbs_phase_t phase;
	lbs_pkg::lbs_phase_t next_phase;
	logic [6:0] step;
	logic all_zero;
	logic [6:0] cur_len;

	assign all_zero = (len[0] | len[1] | len[2] | len[3] | len[4]) == 7'h00;
	assign cur_len = len[phase];

	always_comb begin
		unique case (phase)
			lbs_pkg::PH_FIRST: next_phase = lbs_pkg::PH_SECOND;
			lbs_pkg::PH_SECOND: next_phase = lbs_pkg::PH_THIRD;
			lbs_pkg::PH_THIRD: next_phase = lbs_pkg::PH_FOURTH;
			lbs_pkg::PH_FOURTH: next_phase = lbs_pkg::PH_PAUSE;
			lbs_pkg::PH_PAUSE: next_phase = lbs_pkg::PH_FIRST;
			default: next_phase = lbs_pkg::PH_FIRST;
		endcase
	end

	// A zero-length phase is skipped in one clock so it takes no 64 ms step;
	// a length cut below the steps already run ends the phase at once instead of wrapping
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I || all_zero) begin
			phase <= lbs_pkg::PH_FIRST;
			step <= 7'h00;
		end else if (cur_len == 7'h00 || step >= cur_len) begin
			phase <= next_phase;
			step <= 7'h00;
		end else if (step_tick) begin
			if (step == cur_len - 7'h01) begin
				phase <= next_phase;
				step <= 7'h00;
			end else begin
				step <= step + 7'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// Dimming wave and driver outputs
	// ------------------------------------------------------------
	logic next_lit;
	logic next_wave;
	logic [3:0] target_b;

	// First and third phases light the LED for the on interval; no program means steady
	assign next_lit = all_zero || ((phase == lbs_pkg::PH_FIRST || phase == lbs_pkg::PH_THIRD)
		&& step < {2'b00, on_code});
	assign next_wave = next_lit && slot <= duty_code;
	assign target_b = regs[8][3:0];

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			DIM_WAVE_O <= 1'b0;
			FIRST_SINK_LEVEL_O <= 4'h0;
			SECOND_RAMP_EN_O <= 1'b0;
			PHASE_O <= 3'h0;
		end else begin
			DIM_WAVE_O <= next_wave;
			FIRST_SINK_LEVEL_O <= regs[0][3:0];
			SECOND_RAMP_EN_O <= regs[8][lbs_pkg::RAMP_BIT];
			PHASE_O <= phase;
		end
	end

	// With ramp on, the level moves one code per 8 ms period toward the setting
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			SECOND_SINK_LEVEL_O <= 4'h0;
		end else if (!regs[8][lbs_pkg::RAMP_BIT]) begin
			SECOND_SINK_LEVEL_O <= target_b;
		end else if (slot_tick && slot == lbs_pkg::LAST_SLOT) begin
			if (SECOND_SINK_LEVEL_O < target_b) begin
				SECOND_SINK_LEVEL_O <= SECOND_SINK_LEVEL_O + 4'h1;
			end else if (SECOND_SINK_LEVEL_O > target_b) begin
				SECOND_SINK_LEVEL_O <= SECOND_SINK_LEVEL_O - 4'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_full_duty_high: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(next_lit && duty_code == 5'h1F) |=> DIM_WAVE_O)
		else $error("full duty did not hold the wave high");

	chk_min_duty_low: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(duty_code == 5'h00 && slot != 5'h00) |=> !DIM_WAVE_O)
		else $error("minimum duty wave high outside first slot");

	chk_duty_edge: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(next_lit && slot == duty_code + 5'h01 && duty_code != 5'h1F) |=> !DIM_WAVE_O)
		else $error("wave high beyond its duty slots");

	chk_reserved_read: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		!REG_RDATA_O[7] && (REG_RDATA_O & ~wmask($past(REG_REQ_I.addr))) == 8'h00)
		else $error("reserved bit read as one");

	chk_reset_clear: assert property (@(posedge CLK_I)
		!RST_N_I |=> regs[6] == 8'h00 && regs[8] == 8'h00 && regs[1] == 8'h00)
		else $error("register not cleared by reset");

	chk_step_bound: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(cur_len != 7'h00 && $stable(cur_len)) |-> step < cur_len)
		else $error("phase ran past its length");

	chk_phase_order: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		($past(phase) == lbs_pkg::PH_FOURTH && phase != lbs_pkg::PH_FOURTH && !$past(all_zero))
		|-> phase == lbs_pkg::PH_PAUSE)
		else $error("fourth phase not followed by pause");

	chk_first_level: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		##1 FIRST_SINK_LEVEL_O == $past(regs[0][3:0]))
		else $error("first driver level does not follow its code");

	chk_ramp_gradual: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(regs[8][lbs_pkg::RAMP_BIT] && $past(regs[8][lbs_pkg::RAMP_BIT]) && !$past(slot_tick))
		|-> $stable(SECOND_SINK_LEVEL_O))
		else $error("ramped level moved outside a period boundary");

endmodule

//--- testbench/lbs_sequencer_tb.sv
// Self-checking bench for the LED blink and dimming sequencer
`timescale 1ns/1ns
module lbs_sequencer_tb;
	// ------------------------------------------------------------
	// Signals and counters
	// ------------------------------------------------------------
	localparam int SC = 4;
	localparam int PER = SC * 32;
	localparam int STEP = PER * 8;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	lbs_pkg::lbs_req_t req = '0;
	logic [7:0] rdata;
	logic dim;
	logic [3:0] sink_a;
	logic [3:0] sink_b;
	logic ramp;
	logic [2:0] phase;
	int fail_count = 0;
	int comparisons = 0;
	int cycles = 0;
	int hi;
	int dur;
	int d;
	int lens[5] = '{2, 1, 1, 1, 1};
	logic [7:0] v;

	// Short slot so one 64 ms step is only 1024 cycles
	lbs_sequencer #(.SLOT_CYCLES(SC)) lbs_sequencer_i (
		.CLK_I(clk),
		.RST_N_I(rst_n),
		.REG_REQ_I(req),
		.REG_RDATA_O(rdata),
		.DIM_WAVE_O(dim),
		.FIRST_SINK_LEVEL_O(sink_a),
		.SECOND_SINK_LEVEL_O(sink_b),
		.SECOND_RAMP_EN_O(ramp),
		.PHASE_O(phase)
	);

	// ------------------------------------------------------------
	// Clock, hang guard and helpers
	// ------------------------------------------------------------
	initial forever #5 clk = ~clk;

	// The longest phase wait is a few thousand cycles, so this is generous
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fail_count++;
			end_sim();
		end
	end

	// Writable bits of each register; unmapped places read nothing
	function automatic logic [7:0] mask_of(input logic [7:0] a);
		if (a == 8'h47 || a == 8'h4F) return 8'h2F;
		if (a >= 8'h48 && a <= 8'h4C) return 8'h7F;
		if (a == 8'h4D || a == 8'h4E) return 8'h1F;
		return 8'h00;
	endfunction

	task automatic end_sim();
		if (fail_count == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// Write strobe lasts exactly one cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] dat);
		@(negedge clk);
		req = '{wr: 1'b1, addr: a, wdata: dat};
		@(negedge clk);
		req.wr = 1'b0;
	endtask

	// Read data is registered, one cycle behind the address
	task automatic rd(input logic [7:0] a, output logic [7:0] dat);
		@(negedge clk);
		req.addr = a;
		@(negedge clk);
		dat = rdata;
	endtask

	task automatic dim_check(input logic [4:0] duty);
		wr(8'h4D, {3'h0, duty});
		repeat (2 * PER) @(negedge clk);
		hi = 0;
		repeat (PER) begin
			hi += int'(dim === 1'b1);
			@(negedge clk);
		end
		chk("dim high cycles", 16'((duty + 1) * SC), 16'(hi));
	endtask

	// Count cycles spent in one phase and how many of them had the dimming wave high
	task automatic run_phase(input logic [2:0] p, output int n, output int h);
		n = 0;
		h = 0;
		while (phase !== p) @(negedge clk);
		while (phase === p) begin
			n++;
			h += int'(dim === 1'b1);
			@(negedge clk);
		end
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(25));
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		// Every register and output starts cleared, neighbours included
		for (int a = 8'h46; a <= 8'h50; a++) begin
			rd(8'(a), v);
			chk("reset value", 16'h0000, {8'h00, v});
		end
		chk("reset outputs", 16'h0000, 16'({dim, sink_a, sink_b, ramp, phase}));
		// All-ones first pass hits every reserved bit, then random data
		for (int r = 0; r < 3; r++) begin
			for (int a = 8'h46; a <= 8'h50; a++) begin
				d = (r == 0) ? 255 : int'($urandom);
				wr(8'(a), 8'(d));
				rd(8'(a), v);
				chk("readback", {8'h00, 8'(d) & mask_of(8'(a))}, {8'h00, v});
			end
		end
		// Sink codes without ramp follow the register directly
		wr(8'h47, 8'h0A);
		wr(8'h4F, 8'h07);
		repeat (2) @(negedge clk);
		chk("first sink", 16'h000A, {12'h000, sink_a});
		chk("second sink", 16'h0007, {12'h000, sink_b});
		chk("ramp off", 16'h0000, {15'h0000, ramp});
		// With ramp on the level may not jump straight to the target
		wr(8'h4F, 8'h2F);
		repeat (2) @(negedge clk);
		chk("ramp on", 16'h0001, {15'h0000, ramp});
		chk("ramp not jumped", 16'h0001, {15'h0000, sink_b < 4'hF});
		repeat (9 * PER + 8) @(negedge clk);
		chk("ramp reached", 16'h000F, {12'h000, sink_b});
		// All lengths zero keeps the LED lit so the dimming wave shows alone
		for (int a = 8'h48; a <= 8'h4C; a++) wr(8'(a), 8'h00);
		dim_check(5'h00);
		dim_check(5'h1F);
		v = 8'($urandom);
		dim_check(v[4:0]);
		// Blink program: one lit step in first and third phases
		wr(8'h4E, 8'h01);
		for (int k = 0; k < 5; k++) wr(8'(8'h48 + k), 8'(lens[k]));
		for (int k = 1; k <= 5; k++) begin
			run_phase(3'(k % 5), dur, hi);
			chk("phase length", 16'(lens[k % 5] * STEP), 16'(dur));
			// The random duty still applies, so a lit step shows its duty share of each period
			chk("lit time", 16'(((k % 5) == 0 || (k % 5) == 2) ? (int'(v[4:0]) + 1) * SC * 8 : 0), 16'(hi));
		end
		end_sim();
	end
endmodule
